// [hdl/sio_regs.vh]
// Purpose: register offsets, fields and reset values of the serial port
// Assumes: AXI4-Lite byte addresses, one 32-bit word per register
// Notes:   included by the serial port and its bench
`ifndef SIO_REGS_VH
`define SIO_REGS_VH
`define OFF_CTRL        8'h00
`define OFF_STATUS      8'h04
`define OFF_TXBUF       8'h08
`define OFF_RXBUF       8'h0C
`define OFF_TIMEBASE    8'h10
// control fields
`define CTRL_SCK_LO     0
`define CTRL_SCK_HI     2
`define CTRL_DIR        3
`define CTRL_MODE_LO    4
`define CTRL_MODE_HI    5
`define CTRL_START      6
`define CTRL_INHIBIT    7
`define CTRL_RESET      8'h00
// status fields
`define ST_ACTIVE       7
`define ST_SHIFT        6
`define ST_TXEMPTY      5
`define ST_RXFULL       4
`define ST_TX_UNDERRUN_FLAG        3
`define ST_RXERR        2
`define STATUS_RESET    8'h20
// timebase fields
`define TB_PRESCALE     0
`define TB_LOWPOWER     1
// codes
`define SCK_EXT         3'h7
`define SCK_SLOWEST     3'h0
`define MODE_TX         2'h0
`define MODE_RX         2'h1
`define MODE_TXRX       2'h2
// half periods in system clocks, HALF_FS4 in fs cycles: fc/2^n divides by 2^(n-1)
`define HALF_FC12       16'h0800
`define HALF_FS4        16'h0008
`define BYTE_BITS       4'h8
`endif

// [hdl/sio_axi_slave.v]
// Purpose: AXI4-Lite slave producing single-cycle register strobes
// Assumes: one write and one read outstanding at most
// Notes:   answers OKAY always; unmapped reads return zero
`timescale 1ns/1ps
module sio_axi_slave (
	// clock and reset
	input  wire        clk_sys,
	input  wire        rst_n,
	// write channels
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// read channels
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// register side
	output reg         wr_en,
	output reg  [7:0]  wr_addr,
	output reg  [7:0]  wr_data,
	output reg         rd_en,
	output reg  [7:0]  rd_addr,
	input  wire [7:0]  rd_data
);
	reg have_aw;
	reg have_w;
	reg rd_wait;

	// write path: collect address and data in either order
	always @(posedge clk_sys) begin
		wr_en <= 1'b0;
		if (!rst_n) begin
			have_aw       <= 1'b0;
			have_w        <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= 2'h0;
			wr_addr       <= 8'h00;
			wr_data       <= 8'h00;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				have_aw       <= 1'b1;
				s_axi_awready <= 1'b0;
				wr_addr       <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				have_w       <= 1'b1;
				s_axi_wready <= 1'b0;
				wr_data      <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
			end
			if (have_aw && have_w && !s_axi_bvalid) begin
				wr_en        <= 1'b1;
				s_axi_bvalid <= 1'b1;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				have_aw       <= 1'b0;
				have_w        <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// read path: strobe, then data one cycle later
	always @(posedge clk_sys) begin
		rd_en <= 1'b0;
		if (!rst_n) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= 2'h0;
			rd_addr       <= 8'h00;
			rd_wait       <= 1'b0;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				rd_addr       <= s_axi_araddr;
				rd_en         <= 1'b1;
				rd_wait       <= 1'b1;
			end
			if (rd_wait) begin
				rd_wait      <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= {24'h000000, rd_data};
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end
endmodule // sio_axi_slave

// [hdl/sio_port.v]
// Purpose: clocked synchronous serial port, transmit side complete
// Assumes: registers over AXI4-Lite; pins come in unsynchronised
// Notes:   receive data is sampled into the receive buffer, errors on tx only
// Function
// RULE_01: internal clock code drives serial clock pin, idle high.
// RULE_02: code 000 is fc/2^12 or fs/2^4; 001..110 fc/2^8..2^3.
// RULE_03: internal clock halts when buffer late; resumes within one period.
// RULE_04: external code shifts on clock supplied by partner on pin.
// RULE_05: transmit on falling edge, sample receive on rising edge.
// RULE_06: software changes clock source or order only while idle.
// RULE_07: one order bit: 0 sends bit 7 first, 1 bit 0 first.
// RULE_08: mode code 00 selects transmit-only operation.
// RULE_09: mode code 01 receive-only, 10 transmit and receive.
// RULE_10: transmit buffer write clears the buffer-empty flag.
// RULE_11: transfer-active flag sets at next falling edge after start.
// RULE_12: data out on falling edges; shift flag high edges one to eight.
// RULE_13: buffer-empty set on rising edge; interrupt at next falling edge.
// RULE_14: internal clock waits for a buffer write before starting.
// RULE_15: internal clock loads buffer within one period, then clocks.
// RULE_16: external clock loads buffer at first falling edge after start.
// RULE_17: internal clock stops high after last bit without new byte.
// RULE_18: byte written early goes out back to back without gap.
// RULE_19: external underrun flags error at shift start, then interrupt.
// RULE_20: clearing start finishes byte, drops active, holds data high; with internal clock the code halts the clock mid-byte and keeps active set.
// RULE_21: external stop needs start cleared before next shift begins.
// RULE_22: inhibit aborts at once and reinitialises start, status, buffers.
// RULE_23: underrun flag cleared by writing 0 only; stop keeps it.
// RULE_24: external clock synchronised, edges detected in system domain.
// RULE_25: internal rates come from a free-running prescaler.
//
// The AXI4-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "sio_regs.vh"
module sio_port #(
	parameter FS_DIV = 16'd6104 // system clocks per fs period
) (
	// clock and reset
	input  wire        clk_sys,
	input  wire        rst_n,
	// AXI4-Lite
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output wire [1:0]  s_axi_bresp,
	output wire        s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output wire [31:0] s_axi_rdata,
	output wire [1:0]  s_axi_rresp,
	output wire        s_axi_rvalid,
	input  wire        s_axi_rready,
	// serial pins
	input  wire        serial_clock_pin_in,
	output reg         serial_clock_pin_out,
	output reg         serial_clock_pin_oe,
	output reg         serial_data_out_pin,
	input  wire        serial_data_in_pin,
	// event
	output reg         serial_irq
);
	wire       wr_en;
	wire [7:0] wr_addr;
	wire [7:0] wr_data;
	wire       rd_en;
	wire [7:0] rd_addr;
	reg  [7:0] rd_data;

	sio_axi_slave u_bus (
		.clk_sys       (clk_sys),
		.rst_n         (rst_n),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready),
		.wr_en         (wr_en),
		.wr_addr       (wr_addr),
		.wr_data       (wr_data),
		.rd_en         (rd_en),
		.rd_addr       (rd_addr),
		.rd_data       (rd_data)
	);

	// registers
	reg [2:0]  clock_source;
	reg        bit_order_select;
	reg [1:0]  transfer_mode_field;
	reg        start_bit;
	reg        prescaler_source_bit;
	reg        low_speed_modes;
	reg [7:0]  transmit_buffer;
	reg [7:0]  receive_buffer;
	reg        transfer_active_flag;
	reg        shift_in_progress_flag;
	reg        tx_empty;
	reg        rx_full;
	reg        tx_underrun_flag;
	// engine state
	reg [7:0]  shifter;
	reg [3:0]  bit_cnt;
	reg        loaded;
	reg        irq_pend;
	reg [15:0] pre_cnt;
	reg [15:0] fs_cnt;
	reg        fs_tick;
	reg [3:0]  fs_sub;
	reg        ext_s1;
	reg        ext_s2;
	reg        ext_s3;
	reg        sdi_s1;
	reg        sdi_s2;

	wire wr_ctrl   = wr_en && (wr_addr == `OFF_CTRL);
	wire wr_status = wr_en && (wr_addr == `OFF_STATUS);
	wire wr_tx     = wr_en && (wr_addr == `OFF_TXBUF);
	wire wr_tb     = wr_en && (wr_addr == `OFF_TIMEBASE);
	wire rd_rx     = rd_en && (rd_addr == `OFF_RXBUF);
	wire inhibit   = wr_ctrl && wr_data[`CTRL_INHIBIT];
	wire ext_mode  = (clock_source == `SCK_EXT);
	wire use_fs    = prescaler_source_bit || low_speed_modes;
	wire tx_on     = (transfer_mode_field != `MODE_RX);
	wire rx_on     = (transfer_mode_field != `MODE_TX);

	// RULE_24 sync and edges
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			ext_s1 <= 1'b1;
			ext_s2 <= 1'b1;
			ext_s3 <= 1'b1;
			sdi_s1 <= 1'b1;
			sdi_s2 <= 1'b1;
		end else begin
			ext_s1 <= serial_clock_pin_in;
			ext_s2 <= ext_s1;
			ext_s3 <= ext_s2;
			sdi_s1 <= serial_data_in_pin;
			sdi_s2 <= sdi_s1;
		end
	end
	wire ext_fall = ext_mode && ext_s3 && !ext_s2;
	wire ext_rise = ext_mode && !ext_s3 && ext_s2;

	// RULE_02 half period per clock code
	reg [15:0] half_len;
	always @* begin
		case (clock_source)
		3'h1: half_len = 16'h0080;
		3'h2: half_len = 16'h0040;
		3'h3: half_len = 16'h0020;
		3'h4: half_len = 16'h0010;
		3'h5: half_len = 16'h0008;
		3'h6: half_len = 16'h0004;
		default: half_len = `HALF_FC12;
		endcase
	end

	// RULE_25 free-running prescalers
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			pre_cnt <= 16'h0000;
			fs_cnt  <= 16'h0000;
			fs_tick <= 1'b0;
			fs_sub  <= 4'h0;
		end else begin
			fs_tick <= 1'b0;
			if (fs_cnt >= FS_DIV - 16'd1) begin
				fs_cnt  <= 16'h0000;
				fs_tick <= 1'b1;
				fs_sub  <= fs_sub + 4'h1;
			end else begin
				fs_cnt <= fs_cnt + 16'h0001;
			end
			pre_cnt <= pre_cnt + 16'h0001;
		end
	end
	// half-period tick: fs/2^4 has a half period of 8 fs cycles
	wire fs_half  = fs_tick && (fs_sub[2:0] == 3'h7);
	wire pre_half = ((pre_cnt & (half_len - 16'h0001)) == (half_len - 16'h0001));
	wire int_tick = (use_fs && clock_source == `SCK_SLOWEST) ? fs_half :
			(low_speed_modes ? 1'b0 : pre_half);

	// internal clock edges: RULE_01 idle high, RULE_03 halt keeps it high
	wire byte_end  = (bit_cnt == `BYTE_BITS);
	// RULE_14 RULE_15 wait for data
	wire int_run   = !ext_mode && start_bit && (loaded || !tx_empty || !tx_on);
	// RULE_17 stop high when empty
	wire int_fall  = int_tick && serial_clock_pin_out && int_run && (!byte_end || !tx_empty
			|| !tx_on) && !(bit_cnt == 4'h0 && tx_on && tx_empty);
	wire int_rise  = int_tick && !serial_clock_pin_out;
	// RULE_04 partner clock when external
	wire sc_fall   = ext_mode ? ext_fall : int_fall;
	wire sc_rise   = ext_mode ? ext_rise : int_rise;
	wire new_byte  = sc_fall && (bit_cnt == 4'h0 || byte_end) && start_bit;
	wire next_bit  = bit_order_select ? shifter[0] : shifter[7];

	// clock pin driver
	always @(posedge clk_sys) begin
		if (!rst_n || inhibit) begin
			serial_clock_pin_out <= 1'b1;
			serial_clock_pin_oe  <= 1'b0;
		end else begin
			// RULE_01 drive only with internal clock
			serial_clock_pin_oe <= !ext_mode;
			if (int_fall)
				serial_clock_pin_out <= 1'b0;
			else if (int_rise || ext_mode)
				serial_clock_pin_out <= 1'b1;
		end
	end

	// shift engine
	always @(posedge clk_sys) begin
		if (!rst_n || inhibit) begin
			// RULE_22 abort at once
			shifter                <= 8'h00;
			bit_cnt                <= 4'h0;
			loaded                 <= 1'b0;
			irq_pend               <= 1'b0;
			serial_irq             <= 1'b0;
			transfer_active_flag   <= 1'b0;
			shift_in_progress_flag <= 1'b0;
			tx_empty               <= 1'b1;
			rx_full                <= 1'b0;
			tx_underrun_flag       <= 1'b0;
			serial_data_out_pin    <= 1'b1;
			receive_buffer         <= 8'h00;
			transmit_buffer        <= 8'h00;
		end else begin
			serial_irq <= 1'b0;
			if (wr_tx)
				transmit_buffer <= wr_data;
			if (rd_rx)
				rx_full <= 1'b0;
			// RULE_23 write 0 clears, write 1 ignored
			if (wr_status && !wr_data[`ST_TX_UNDERRUN_FLAG])
				tx_underrun_flag <= 1'b0;
			// RULE_10 buffer write clears empty
			if (wr_tx)
				tx_empty <= 1'b0;
			if (new_byte) begin
				// RULE_11 active on falling edge
				transfer_active_flag   <= 1'b1;
				// RULE_12 flag high edges one to eight
				shift_in_progress_flag <= 1'b1;
				bit_cnt                <= 4'h1;
				loaded                 <= 1'b1;
				// RULE_16 RULE_18 load at falling edge, no gap
				if (tx_on && !tx_empty) begin
					shifter             <= bit_order_select ? {1'b0, transmit_buffer[7:1]}
							: {transmit_buffer[6:0], 1'b0};
					serial_data_out_pin <= bit_order_select ? transmit_buffer[0]
							: transmit_buffer[7];
				end else if (tx_on) begin
					// RULE_19 underrun at shift start
					tx_underrun_flag <= 1'b1;
					irq_pend         <= 1'b1;
					serial_data_out_pin <= 1'b1;
				end
			end else if (sc_fall && bit_cnt != 4'h0 && !byte_end) begin
				// RULE_05 RULE_07 drive next bit on falling edge
				serial_data_out_pin <= tx_on ? next_bit : 1'b1;
				shifter <= bit_order_select ? {1'b0, shifter[7:1]} : {shifter[6:0], 1'b0};
				bit_cnt <= bit_cnt + 4'h1;
				// RULE_12 flag drops at eighth edge
				if (bit_cnt == 4'h7) begin
					bit_cnt                <= `BYTE_BITS;
					shift_in_progress_flag <= 1'b0;
				end
			end else if (byte_end && !start_bit && (ext_mode ? ext_s2
					: (int_tick && serial_clock_pin_out))) begin
				// RULE_20 stop after byte, data high
				transfer_active_flag <= 1'b0;
				bit_cnt              <= 4'h0;
				loaded               <= 1'b0;
				serial_data_out_pin  <= 1'b1;
			end
			// RULE_13 empty set on rising edge after load
			if (sc_rise && loaded && bit_cnt == 4'h1 && tx_on && !wr_tx) begin
				tx_empty <= 1'b1;
				irq_pend <= 1'b1;
			end
			// RULE_09 RULE_07 sample each rising edge
			if (sc_rise && rx_on && bit_cnt != 4'h0) begin
				receive_buffer <= bit_order_select ? {sdi_s2, receive_buffer[7:1]}
						: {receive_buffer[6:0], sdi_s2};
				if (byte_end)
					rx_full <= 1'b1;
			end
			// RULE_13 interrupt at following falling edge
			if (irq_pend && sc_fall && !new_byte) begin
				serial_irq <= 1'b1;
				irq_pend   <= 1'b0;
			end
			if (!start_bit && !transfer_active_flag)
				shift_in_progress_flag <= 1'b0;
		end
	end

	// control and timebase registers
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			clock_source         <= 3'h0;
			bit_order_select     <= 1'b0;
			transfer_mode_field  <= `MODE_TX;
			start_bit            <= 1'b0;
			prescaler_source_bit <= 1'b0;
			low_speed_modes      <= 1'b0;
		end else begin
			if (wr_ctrl) begin
				clock_source        <= wr_data[`CTRL_SCK_HI:`CTRL_SCK_LO];
				bit_order_select    <= wr_data[`CTRL_DIR];
				// RULE_08 mode code select
				transfer_mode_field <= wr_data[`CTRL_MODE_HI:`CTRL_MODE_LO];
				// RULE_22 inhibit clears start
				start_bit <= wr_data[`CTRL_START] && !wr_data[`CTRL_INHIBIT];
			end
			if (wr_tb) begin
				prescaler_source_bit <= wr_data[`TB_PRESCALE];
				low_speed_modes      <= wr_data[`TB_LOWPOWER];
			end
		end
	end

	// read mux
	always @* begin
		case (rd_addr)
		`OFF_CTRL:     rd_data = {1'b0, start_bit, transfer_mode_field,
				bit_order_select, clock_source};
		`OFF_STATUS:   rd_data = {transfer_active_flag, shift_in_progress_flag, tx_empty,
				rx_full, tx_underrun_flag, 3'h0};
		`OFF_RXBUF:    rd_data = receive_buffer;
		`OFF_TIMEBASE: rd_data = {6'h00, low_speed_modes, prescaler_source_bit};
		default:       rd_data = 8'h00;
		endcase
	end
endmodule // sio_port

// [bench/sio_port_properties.sv]
// Purpose: port assertions of the serial port
// Assumes: one clock, reset synchronous active low
// Notes:   bound below to every serial port
`timescale 1ns/1ps
module sio_port_properties (
	// clock and reset
	input wire       clk_sys,
	input wire       rst_n,
	// bus handshakes
	input wire       s_axi_awvalid,
	input wire       s_axi_awready,
	input wire       s_axi_wvalid,
	input wire       s_axi_wready,
	input wire [1:0] s_axi_bresp,
	input wire       s_axi_bvalid,
	input wire       s_axi_arvalid,
	input wire       s_axi_arready,
	input wire       s_axi_rvalid,
	// serial clock and event
	input wire       serial_clock_pin_out,
	input wire       serial_clock_pin_oe,
	input wire       serial_irq
);
	default clocking dc @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	// both write halves taken on one edge
	sequence wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	// read address taken
	sequence rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	// write answer and refusal
	AST_B_LATENCY: assert property (wr_taken |-> ##2 s_axi_bvalid)
		else $error("write response not two cycles after request");
	AST_AW_REFUSED: assert property (wr_taken |=> !s_axi_awready [*2])
		else $error("write address accepted while busy");
	AST_W_REFUSED: assert property (wr_taken |=> !s_axi_wready ##1 !s_axi_wready)
		else $error("write data accepted while busy");
	AST_B_OKAY: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0)
		else $error("write response not okay");
	// read answer and refusal
	AST_R_LATENCY: assert property (rd_taken |-> ##2 s_axi_rvalid)
		else $error("read data not two cycles after request");
	AST_AR_REFUSED: assert property (rd_taken |=> !s_axi_arready ##1 !s_axi_arready)
		else $error("read address accepted while busy");
	// serial clock idle level and event pulse
	AST_IDLE_HIGH: assert property (!serial_clock_pin_oe |-> serial_clock_pin_out)
		else $error("serial clock low while not driven");
	AST_IRQ_PULSE: assert property ($rose(serial_irq) |=> !serial_irq)
		else $error("interrupt pulse longer than one cycle");
endmodule // sio_port_properties

bind sio_port sio_port_properties chk (
	.clk_sys(clk_sys), .rst_n(rst_n),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rvalid(s_axi_rvalid), .serial_clock_pin_out(serial_clock_pin_out),
	.serial_clock_pin_oe(serial_clock_pin_oe), .serial_irq(serial_irq)
);

// [bench/serial_partner.sv]
// Purpose: far-side serial peripheral model
// Assumes: receives on rising clock edges, supplies clock on request
// Notes:   answers each byte with an echo of the byte before
`timescale 1ns/1ps
module serial_partner #(
	parameter HALF = 8 // half period of supplied clock, system clocks
) (
	// clock
	input  wire        clk_sys,
	// serial pins
	input  wire        sck,
	input  wire        sdo,
	output reg         ext_sck,
	output reg         sdi,
	// results
	output reg  [7:0]  rx_byte,
	output reg  [31:0] rx_count,
	output reg  [31:0] period,
	output reg  [31:0] pmax
);
	reg  [7:0] shift;
	reg  [3:0] bits;
	reg  [7:0] echo;
	time       last;
	// start values
	initial begin
		ext_sck = 1'b1;
		sdi = 1'b1;
		echo = 8'hFF;
		rx_count = 32'h0;
		bits = 4'h0;
		last = 0;
	end
	// answer on falling edge, msb first
	always @(negedge sck) begin
		sdi <= echo[7];
		echo <= {echo[6:0], 1'b1};
	end
	// sample on rising edge, msb first
	always @(posedge sck) begin
		if (last != 0) begin
			period = ($time - last) / 5;
			if (period > pmax)
				pmax = period;
		end
		last = $time;
		shift = {shift[6:0], sdo};
		bits = bits + 4'h1;
		if (bits == 4'h8) begin
			bits = 4'h0;
			rx_byte = shift;
			echo = shift;
			rx_count = rx_count + 32'h1;
		end
	end
	// realign framing and gap tracking
	task clear;
		begin
			bits = 4'h0;
			last = 0;
			pmax = 32'h0;
		end
	endtask
	task clock_byte;
		integer k;
		begin
			for (k = 0; k < 16; k = k + 1) begin
				repeat (HALF) @(posedge clk_sys);
				ext_sck <= ~ext_sck;
			end
		end
	endtask
endmodule // serial_partner

// [bench/sio_port_bench.sv]
// Purpose: self-checking bench of the serial port
// Assumes: partner model on the serial pins
// Notes:   random bytes from a fixed seed
`timescale 1ns/1ps
`include "sio_regs.vh"
module sio_port_bench;
	reg         clk_sys = 1'b0;
	reg         rst_n = 1'b0;
	reg  [7:0]  awaddr = 8'h00;
	reg         awvalid = 1'b0;
	reg  [31:0] wdata = 32'h0;
	reg         wvalid = 1'b0;
	reg         bready = 1'b0;
	reg  [7:0]  araddr = 8'h00;
	reg         arvalid = 1'b0;
	reg         rready = 1'b0;
	reg  [31:0] rd;
	reg  [7:0]  d, e;
	wire        awready, wready, bvalid, arready, rvalid;
	wire [31:0] rdata, rx_count, period, pmax;
	wire        sck_out, sck_oe, sdo, ext_sck, sdi, irq;
	wire [7:0]  rx_byte;
	wire        sck = sck_oe ? sck_out : ext_sck;
	integer     miscompares = 0;
	integer     comparisons = 0;
	integer     irqs = 0;
	integer     i, n0, q;
	// system clock
	always #2.5 clk_sys = ~clk_sys;
	// design and partner
	sio_port #(.FS_DIV(16'd16)) dut (
		.clk_sys(clk_sys), .rst_n(rst_n),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.serial_clock_pin_in(sck), .serial_clock_pin_out(sck_out),
		.serial_clock_pin_oe(sck_oe), .serial_data_out_pin(sdo),
		.serial_data_in_pin(sdi), .serial_irq(irq)
	);
	serial_partner #(.HALF(8)) p (
		.clk_sys(clk_sys), .sck(sck), .sdo(sdo), .ext_sck(ext_sck), .sdi(sdi),
		.rx_byte(rx_byte), .rx_count(rx_count), .period(period), .pmax(pmax)
	);
	// count event pulses
	always @(posedge clk_sys) begin
		if (irq === 1'b1)
			irqs = irqs + 1;
	end
	task check(input [31:0] got, input [31:0] exp);
		begin
			comparisons = comparisons + 1;
			if (got !== exp) begin
				miscompares = miscompares + 1;
				$display("FAIL t=%0t got %h want %h", $time, got, exp);
			end
		end
	endtask
	task wr(input [7:0] a, input [7:0] v);
		integer k;
		begin
			k = 0;
			awaddr <= a;
			wdata <= {24'h0, v};
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
			while (k < 200) begin
				@(posedge clk_sys);
				k = k + 1;
				if (awready === 1'b1)
					awvalid <= 1'b0;
				if (wready === 1'b1)
					wvalid <= 1'b0;
				if (bvalid === 1'b1) begin
					bready <= 1'b0;
					k = 500;
				end
			end
			// let the release edge pass before the next call
			@(posedge clk_sys);
			check(k, 500);
		end
	endtask
	task rdr(input [7:0] a);
		integer k;
		begin
			k = 0;
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
			while (k < 200) begin
				@(posedge clk_sys);
				k = k + 1;
				if (arready === 1'b1)
					arvalid <= 1'b0;
				if (rvalid === 1'b1) begin
					rready <= 1'b0;
					rd = rdata;
					k = 500;
				end
			end
			@(posedge clk_sys);
			check(k, 500);
		end
	endtask
	task wait_ge(input sel, input [31:0] n);
		integer k;
		begin
			k = 0;
			while ((sel ? irqs : rx_count) < n && k < 9000) begin
				@(posedge clk_sys);
				k = k + 1;
			end
			check(k < 9000, 1);
		end
	endtask
	// bit order as the msb-first partner sees it
	function [7:0] on_wire(input [7:0] v, input lsb);
		integer k;
		begin
			for (k = 0; k < 8; k = k + 1)
				on_wire[k] = lsb ? v[7 - k] : v[k];
		end
	endfunction
	task print_verdict;
		begin
			$display("comparisons %0d miscompares %0d", comparisons, miscompares);
			if (miscompares == 0 && comparisons > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask
	// watchdog
	initial begin
		#400000;
		miscompares = miscompares + 1;
		print_verdict;
	end
	// tests
	initial begin
		void'($urandom(32'h51D0748F));
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		rdr(`OFF_CTRL);
		check(rd, 32'h0);
		rdr(`OFF_STATUS);
		check(rd, 32'h20);
		rdr(8'h14);
		check(rd, 32'h0);
		wr(`OFF_TXBUF, 8'h5A);
		rdr(`OFF_STATUS);
		check(rd, 32'h0);
		wr(`OFF_CTRL, 8'h80);
		rdr(`OFF_STATUS);
		check(rd, 32'h20);
		$display("done: reset and buffer");
		// code 0 first runs from the subclock
		wr(`OFF_TIMEBASE, 8'h01);
		for (i = 0; i < 7; i = i + 1) begin
			if (i == 1)
				wr(`OFF_TIMEBASE, 8'h00);
			d = 8'($urandom);
			n0 = rx_count;
			q = irqs;
			p.clear();
			wr(`OFF_CTRL, {4'h4, i[0], i[2:0]});
			repeat (600) @(posedge clk_sys);
			check(rx_count, n0);
			wr(`OFF_TXBUF, d);
			wait_ge(0, n0 + 1);
			check(rx_byte, on_wire(d, i[0]));
			check(period, (i == 0) ? 32'd256 : 1 << (9 - i));
			repeat (1200) @(posedge clk_sys);
			check(sck, 1);
			check(irqs, q + 1);
			wr(`OFF_CTRL, {4'h0, i[0], i[2:0]});
			repeat (600) @(posedge clk_sys);
			rdr(`OFF_STATUS);
			check(rd[7], 0);
			check(sdo, 1);
		end
		$display("done: internal rates");
		d = 8'($urandom);
		e = 8'($urandom);
		n0 = rx_count;
		q = irqs;
		p.clear();
		wr(`OFF_TXBUF, e);
		wr(`OFF_CTRL, 8'h64);
		wait_ge(1, q + 1);
		wr(`OFF_TXBUF, d);
		wait_ge(0, n0 + 2);
		check(rx_byte, d);
		check(pmax, 32);
		rdr(`OFF_RXBUF);
		check(rd, e);
		wr(`OFF_CTRL, 8'h24);
		repeat (200) @(posedge clk_sys);
		$display("done: back to back");
		d = 8'($urandom);
		q = irqs;
		p.clear();
		wr(`OFF_TXBUF, d);
		wr(`OFF_CTRL, 8'h4F);
		p.clock_byte();
		repeat (2) @(posedge clk_sys);
		check(rx_byte, on_wire(d, 1));
		p.clock_byte();
		repeat (10) @(posedge clk_sys);
		rdr(`OFF_STATUS);
		check(rd[3], 1);
		check(irqs, q + 2);
		wr(`OFF_CTRL, 8'h0F);
		wr(`OFF_STATUS, 8'h08);
		rdr(`OFF_STATUS);
		check(rd[3], 1);
		wr(`OFF_STATUS, 8'h00);
		rdr(`OFF_STATUS);
		check(rd[3], 0);
		$display("done: external clock");
		wr(`OFF_TXBUF, 8'($urandom));
		wr(`OFF_CTRL, 8'h41);
		repeat (600) @(posedge clk_sys);
		wr(`OFF_CTRL, 8'h81);
		repeat (3) @(posedge clk_sys);
		check(sck, 1);
		rdr(`OFF_STATUS);
		check(rd, 32'h20);
		rdr(`OFF_CTRL);
		check(rd[6], 0);
		$display("done: inhibit");
		print_verdict;
	end
endmodule // sio_port_bench
